// ---- dpsf_pkg.sv ----
// constants, timing and enumerations for the semaphore flag host controller
// assumes one 100 MHz clock and a dual-port memory whose flag space sits behind one port
package dpsf_pkg;

  // ------------------------------------------------------------
  // pin widths
  // ------------------------------------------------------------
  localparam int DATA_W     = 16;          // data pins of the port
  localparam int ADDR_W     = 15;          // address pins of the port
  localparam int IDX_W      = 3;           // flag index lines
  localparam int UPPER_W    = ADDR_W - IDX_W;  // address lines ignored in flag space
  localparam int FLAG_COUNT = 8;           // number of flags
  localparam int INIT_W     = 4;           // width of init write counter

  // ------------------------------------------------------------
  // flag polarity
  // ------------------------------------------------------------
  localparam logic FLAG_HELD = 1'b0;       // reads low on the owning side
  localparam logic FLAG_FREE = 1'b1;       // writing this releases or withdraws

  // ------------------------------------------------------------
  // access timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;       // clock period
  localparam int T_SETUP_NS    = 10;       // select and address before strobe
  localparam int T_STROBE_NS   = 30;       // output enable or write pulse width
  localparam int T_RECOVER_NS  = 20;       // all strobes inactive between accesses
  localparam int SETUP_CYC   = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC  = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W       = 4;          // phase counter width

  // ------------------------------------------------------------
  // polling
  // ------------------------------------------------------------
  localparam int POLL_W    = 5;            // poll counter width
  localparam int MAX_POLLS = 16;           // reads after a failed claim before withdrawing

  // user commands
  typedef enum logic [1:0] {
    OP_INIT,                               // free all flags from this side
    OP_CLAIM,                              // request and confirm a token
    OP_RELEASE,                            // give a token back
    OP_PEEK                                // read one flag
  } dpsf_op_t;

endpackage

// ---- dpsf_acc_if.sv ----
// carrier between the command engine and the pin access sequencer
// assumes both ends run on the same clock
`timescale 1ns/1ps

interface dpsf_acc_if;
  import dpsf_pkg::*;

  logic             start;    // one-cycle request for an access
  logic             isWrite;  // write when high, read when low
  logic [IDX_W-1:0] index;    // flag to access
  logic             wrBit;    // value written
  logic             busy;     // sequencer not idle
  logic             done;     // one-cycle end of access
  logic             rdBit;    // value read

  // command engine side
  modport engine (
    output start,
    output isWrite,
    output index,
    output wrBit,
    input  busy,
    input  done,
    input  rdBit
  );

  // sequencer side
  modport unit (
    input  start,
    input  isWrite,
    input  index,
    input  wrBit,
    output busy,
    output done,
    output rdBit
  );
endinterface

// ---- dpsf_access.sv ----
// pin sequencer: one flag-space read or write per request
// assumes the engine raises start only while busy is low
`timescale 1ns/1ps

module dpsf_access (
  input  wire logic                       clk,
  input  wire logic                       rst,
  dpsf_acc_if.unit                        acc,
  output logic                            tokenSpaceSelectN,
  output logic                            oeN,
  output logic                            rwN,
  output logic [dpsf_pkg::IDX_W-1:0]      flagIndexLines,
  output logic [dpsf_pkg::UPPER_W-1:0]    upperAddrLines,
  output logic [dpsf_pkg::DATA_W-1:0]     dataOut,
  output logic                            dataOe,
  input  wire logic [dpsf_pkg::DATA_W-1:0] dataIn
);
  import dpsf_pkg::*;

  // ------------------------------------------------------------
  // phase machine
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER} dpsf_ph_t;

  dpsf_ph_t           phase_reg;   // current phase
  logic [CNT_W-1:0]   cnt_reg;     // cycles spent in phase
  logic               wr_reg;      // latched direction
  logic               bit_reg;     // latched write value
  logic               rd_reg;      // captured flag value
  logic               lastCyc;     // final cycle of a phase

  // end of current phase
  always_comb begin
    lastCyc = 1'b0;
    unique case (phase_reg)
      ST_IDLE:    lastCyc = 1'b0;
      ST_SETUP:   lastCyc = (cnt_reg == CNT_W'(SETUP_CYC - 1));
      ST_STROBE:  lastCyc = (cnt_reg == CNT_W'(STROBE_CYC - 1));
      ST_RECOVER: lastCyc = (cnt_reg == CNT_W'(RECOVER_CYC - 1));
    endcase
  end

  // phase and counter advance
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= ST_IDLE;
      cnt_reg   <= '0;
    end else if (phase_reg == ST_IDLE) begin
      cnt_reg <= '0;
      if (acc.start) begin
        phase_reg <= ST_SETUP;
      end
    end else if (lastCyc) begin
      cnt_reg <= '0;
      unique case (phase_reg)
        ST_SETUP:   phase_reg <= ST_STROBE;
        ST_STROBE:  phase_reg <= ST_RECOVER;
        ST_RECOVER: phase_reg <= ST_IDLE;
        ST_IDLE:    phase_reg <= ST_IDLE;
      endcase
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // request capture; index lines keep the last request while idle, upper lines tied low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg         <= 1'b0;
      bit_reg        <= FLAG_FREE;
      flagIndexLines <= '0;
    end else if (phase_reg == ST_IDLE && acc.start) begin
      wr_reg         <= acc.isWrite;
      bit_reg        <= acc.wrBit;
      flagIndexLines <= acc.index;
    end
  end

  assign upperAddrLines = '0;               // ignored in flag space

  // strobes: select over setup and strobe, then a gap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tokenSpaceSelectN <= 1'b1;
      oeN               <= 1'b1;
      rwN               <= 1'b1;
      dataOe            <= 1'b0;
      dataOut           <= '0;
    end else begin
      tokenSpaceSelectN <= !((phase_reg == ST_IDLE && acc.start) ||
                             (phase_reg == ST_SETUP) ||
                             (phase_reg == ST_STROBE && !lastCyc));
      oeN    <= !(!wr_reg && ((phase_reg == ST_SETUP && lastCyc) ||
                              (phase_reg == ST_STROBE && !lastCyc)));
      rwN    <= !(wr_reg && ((phase_reg == ST_SETUP && lastCyc) ||
                             (phase_reg == ST_STROBE && !lastCyc)));
      dataOe <= wr_reg && ((phase_reg == ST_SETUP && lastCyc) ||
                           (phase_reg == ST_STROBE && !lastCyc));
      dataOut <= {DATA_W{bit_reg}};         // only bit zero matters
    end
  end

  // sample at the end of the read strobe; bit zero carries the flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_reg <= FLAG_FREE;
    end else if (phase_reg == ST_STROBE && lastCyc && !wr_reg) begin
      rd_reg <= dataIn[0];
    end
  end

  assign acc.busy  = (phase_reg != ST_IDLE);
  assign acc.done  = (phase_reg == ST_RECOVER) && lastCyc;
  assign acc.rdBit = rd_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_readStrobe;
    @(posedge clk) disable iff (rst)
      $fell(oeN) |-> (!oeN && !tokenSpaceSelectN)[*3] ##1 (oeN && tokenSpaceSelectN)[*2];
  endproperty
  a_readStrobe: assert property (p_readStrobe)
    else $error("read strobe width or gap wrong");

  // index must not move while one access keeps the select low
  property p_upperZero;
    @(posedge clk) disable iff (rst)
      (!tokenSpaceSelectN && $past(!tokenSpaceSelectN)) |->
        ($stable(flagIndexLines) && upperAddrLines == '0);
  endproperty
  a_upperZero: assert property (p_upperZero)
    else $error("upper address lines not low in flag space");

  property p_writeData;
    @(posedge clk) disable iff (rst)
      !rwN |-> (dataOe && !tokenSpaceSelectN && oeN && dataOut[0] == bit_reg);
  endproperty
  a_writeData: assert property (p_writeData)
    else $error("write pulse without proper data drive");
endmodule

// ---- dpsf_host.sv ----
// host controller for one port of a two-port flag set: init, claim, release, peek
// assumes the device port pins are wired to the outputs here, chip enable held inactive
`timescale 1ns/1ps

module dpsf_host (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        cmdValid,
  output logic                             cmdReady,
  input  wire dpsf_pkg::dpsf_op_t          cmdOp,
  input  wire logic [dpsf_pkg::IDX_W-1:0]  cmdIndex,
  output logic                             rspValid,
  output logic                             rspGranted,
  output logic                             rspFlag,
  output logic [dpsf_pkg::FLAG_COUNT-1:0]  heldMask,
  output logic                             tokenSpaceSelectN,
  output logic                             oeN,
  output logic                             rwN,
  output logic [dpsf_pkg::IDX_W-1:0]       flagIndexLines,
  output logic [dpsf_pkg::UPPER_W-1:0]     upperAddrLines,
  output logic [dpsf_pkg::DATA_W-1:0]      dataOut,
  output logic                             dataOe,
  input  wire logic [dpsf_pkg::DATA_W-1:0] dataIn
);
  import dpsf_pkg::*;

  // ------------------------------------------------------------
  // engine state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    S_INIT, S_IDLE, S_CLAIM_WR, S_CLAIM_RD, S_WITHDRAW, S_RELEASE, S_PEEK
  } dpsf_st_t;

  dpsf_st_t          state_reg;     // engine state
  logic [IDX_W-1:0]  idx_reg;       // flag of current command
  logic [IDX_W-1:0]  initIdx_reg;   // flag being freed at init
  logic [POLL_W-1:0] poll_reg;      // reads after a failed claim
  logic              issued_reg;    // access started, waiting for done
  logic              initDone_reg;  // start-up freeing finished

  dpsf_acc_if acc ();                // link to pin sequencer

  // ------------------------------------------------------------
  // pin sequencer
  // ------------------------------------------------------------
  dpsf_access u_access (
    .clk               (clk),
    .rst               (rst),
    .acc               (acc),
    .tokenSpaceSelectN (tokenSpaceSelectN),
    .oeN               (oeN),
    .rwN               (rwN),
    .flagIndexLines    (flagIndexLines),
    .upperAddrLines    (upperAddrLines),
    .dataOut           (dataOut),
    .dataOe            (dataOe),
    .dataIn            (dataIn)
  );

  // access request from state; one access per issue
  always_comb begin
    acc.start   = (state_reg != S_IDLE) && !issued_reg && !acc.busy;
    acc.index   = (state_reg == S_INIT) ? initIdx_reg : idx_reg;
    acc.isWrite = 1'b1;
    acc.wrBit   = FLAG_FREE;
    unique case (state_reg)
      S_CLAIM_WR: acc.wrBit   = FLAG_HELD;         // request token
      S_CLAIM_RD: acc.isWrite = 1'b0;              // confirm after write
      S_PEEK:     acc.isWrite = 1'b0;              // plain read
      default:    acc.wrBit   = FLAG_FREE;         // init, release, withdraw
    endcase
  end

  assign cmdReady = (state_reg == S_IDLE);

  // issue tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      issued_reg <= 1'b0;
    end else if (acc.done) begin
      issued_reg <= 1'b0;
    end else if (acc.start) begin
      issued_reg <= 1'b1;
    end
  end

  // command engine; flags are unknown at power-up so init runs first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= S_INIT;
      idx_reg      <= '0;
      initIdx_reg  <= '0;
      poll_reg     <= '0;
      initDone_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (cmdValid) begin
            idx_reg     <= cmdIndex;
            initIdx_reg <= '0;
            poll_reg    <= '0;
            unique case (cmdOp)
              OP_INIT:    state_reg <= S_INIT;
              OP_CLAIM:   state_reg <= S_CLAIM_WR;
              OP_RELEASE: state_reg <= S_RELEASE;
              OP_PEEK:    state_reg <= S_PEEK;
            endcase
          end
        end
        S_INIT: begin
          if (acc.done) begin
            initIdx_reg <= initIdx_reg + 1'b1;
            if (initIdx_reg == IDX_W'(FLAG_COUNT - 1)) begin
              state_reg    <= S_IDLE;
              initDone_reg <= 1'b1;         // every flag written free
            end
          end
        end
        S_CLAIM_WR: begin
          if (acc.done) begin
            state_reg <= S_CLAIM_RD;        // write then read
          end
        end
        S_CLAIM_RD: begin
          if (acc.done) begin
            if (acc.rdBit == FLAG_HELD) begin
              state_reg <= S_IDLE;          // zero means ours
            end else if (poll_reg == POLL_W'(MAX_POLLS)) begin
              state_reg <= S_WITHDRAW;      // give up and withdraw
            end else begin
              poll_reg <= poll_reg + 1'b1;  // still pending, read again
            end
          end
        end
        S_WITHDRAW, S_RELEASE, S_PEEK: begin
          if (acc.done) begin
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  // answers and held tokens
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rspValid   <= 1'b0;
      rspGranted <= 1'b0;
      rspFlag    <= FLAG_FREE;
      heldMask   <= '0;
    end else begin
      rspValid <= 1'b0;
      if (acc.done) begin
        unique case (state_reg)
          S_INIT: begin
            heldMask[initIdx_reg] <= 1'b0;
            if (initIdx_reg == IDX_W'(FLAG_COUNT - 1)) begin
              rspValid   <= 1'b1;
              rspGranted <= 1'b0;
              rspFlag    <= FLAG_FREE;
            end
          end
          S_CLAIM_RD: begin
            if (acc.rdBit == FLAG_HELD) begin
              heldMask[idx_reg] <= 1'b1;
              rspValid   <= 1'b1;
              rspGranted <= 1'b1;
              rspFlag    <= acc.rdBit;
            end
          end
          S_WITHDRAW, S_RELEASE: begin
            heldMask[idx_reg] <= 1'b0;
            rspValid   <= 1'b1;
            rspGranted <= 1'b0;
            rspFlag    <= FLAG_FREE;
          end
          S_PEEK: begin
            rspValid   <= 1'b1;
            rspGranted <= (acc.rdBit == FLAG_HELD);
            rspFlag    <= acc.rdBit;
          end
          default: rspValid <= 1'b0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic             lastWrBit_reg;  // value of last write access
  logic [IDX_W-1:0] lastWrIdx_reg;  // flag of last write access
  logic [INIT_W-1:0] initWr_reg;    // ones written during start-up

  // helper history for checks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastWrBit_reg <= FLAG_FREE;
      lastWrIdx_reg <= '0;
      initWr_reg    <= '0;
    end else if (acc.start && acc.isWrite) begin
      lastWrBit_reg <= acc.wrBit;
      lastWrIdx_reg <= acc.index;
      if (!initDone_reg && acc.wrBit == FLAG_FREE) begin
        initWr_reg <= initWr_reg + 1'b1;
      end
    end
  end

  property p_writeBeforeRead;
    @(posedge clk) disable iff (rst)
      (acc.start && state_reg == S_CLAIM_RD) |->
        (!acc.isWrite && lastWrBit_reg == FLAG_HELD && lastWrIdx_reg == acc.index);
  endproperty
  a_writeBeforeRead: assert property (p_writeBeforeRead)
    else $error("claim read not preceded by zero write to same flag");

  property p_withdraw;
    @(posedge clk) disable iff (rst)
      (state_reg == S_CLAIM_RD && acc.done && acc.rdBit && poll_reg == POLL_W'(MAX_POLLS))
        |=> ##[0:2] (acc.start && acc.isWrite && acc.wrBit == FLAG_FREE);
  endproperty
  a_withdraw: assert property (p_withdraw)
    else $error("failed claim not withdrawn with a one");

  property p_releaseOne;
    @(posedge clk) disable iff (rst)
      (acc.start && state_reg == S_RELEASE) |-> (acc.isWrite && acc.wrBit == FLAG_FREE);
  endproperty
  a_releaseOne: assert property (p_releaseOne)
    else $error("release did not write a one");

  property p_initFirst;
    @(posedge clk) disable iff (rst)
      cmdReady |-> (initDone_reg && initWr_reg == INIT_W'(FLAG_COUNT));
  endproperty
  a_initFirst: assert property (p_initFirst)
    else $error("ready before every flag was freed");

  property p_grantHeld;
    @(posedge clk) disable iff (rst)
      (state_reg == S_CLAIM_RD && acc.done && acc.rdBit == FLAG_HELD)
        |=> (rspValid && rspGranted && heldMask[$past(idx_reg)]);
  endproperty
  a_grantHeld: assert property (p_grantHeld)
    else $error("zero read not reported as granted");

  c_granted: cover property (@(posedge clk) disable iff (rst) rspValid && rspGranted);
  c_withdrawn: cover property (@(posedge clk) disable iff (rst)
    state_reg == S_WITHDRAW && acc.done);
  c_polled: cover property (@(posedge clk) disable iff (rst)
    state_reg == S_CLAIM_RD && poll_reg == POLL_W'(2));
endmodule

// ---- dpsf_dev_model.sv ----
// behavioural two-port flag device: port A on host pins, port B on bench strobes
// assumes host pins change only just after the bench clock rising edge
`timescale 1ns/1ps

module dpsf_dev_model (
  input  wire logic                               clk,
  input  wire logic                               tokenSpaceSelectN,
  input  wire logic                               oeN,
  input  wire logic                               rwN,
  input  wire logic [dpsf_pkg::IDX_W-1:0]         flagIndexLines,
  input  wire logic [dpsf_pkg::DATA_W-1:0]        dataOut,
  input  wire logic                               dataOe,
  output logic      [dpsf_pkg::DATA_W-1:0]        dataIn,
  input  wire logic                               bWr,
  input  wire logic [dpsf_pkg::IDX_W-1:0]         bIdx,
  input  wire logic                               bBit,
  output logic      [dpsf_pkg::FLAG_COUNT-1:0]    bFlag,
  output int                                      pinErr
);
  import dpsf_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic             reqA  [FLAG_COUNT];  // port A request latches
  logic             reqB  [FLAG_COUNT];  // port B request latches
  logic [1:0]       owner [FLAG_COUNT];  // 0 free, 1 port A, 2 port B
  logic             wrPend, wrBit, rdOpen, rdVal;
  logic [IDX_W-1:0] wrIdx;

  // owner keeps it until its own latch goes high
  function automatic void settle(int i);
    if (owner[i] == 2'd1 && reqA[i]) owner[i] = reqB[i] ? 2'd0 : 2'd2;
    else if (owner[i] == 2'd2 && reqB[i]) owner[i] = reqA[i] ? 2'd0 : 2'd1;
    // free flag: first low latch wins, port A on a tie
    if (owner[i] == 2'd0) owner[i] = !reqA[i] ? 2'd1 : (!reqB[i] ? 2'd2 : 2'd0);
  endfunction

  // latches power up low, the unkind case
  initial begin
    for (int i = 0; i < FLAG_COUNT; i++) begin
      reqA[i] = 1'b0;
      reqB[i] = 1'b0;
      owner[i] = 2'd0;
      settle(i);
    end
    {wrPend, wrBit, rdOpen, rdVal, wrIdx, pinErr} = '0;
    dataIn = 16'h0000;
  end

  // port A write commits when strobe or select ends
  always @(posedge clk) begin
    if (!tokenSpaceSelectN && !rwN) begin
      wrPend = 1'b1;
      wrBit = dataOut[0];
      wrIdx = flagIndexLines;
      if (!dataOe || !oeN) pinErr++;
    end else if (wrPend) begin
      wrPend = 1'b0;
      reqA[wrIdx] = wrBit;
      settle(int'(wrIdx));
    end
    if (bWr) begin
      reqB[bIdx] = bBit;
      settle(int'(bIdx));
    end
    // read value frozen while select and enable stay low
    if (!tokenSpaceSelectN && !oeN) begin
      if (dataOe) pinErr++;      // host drives data during a read
      if (!rdOpen) rdVal = (owner[flagIndexLines] == 2'd1) ? FLAG_HELD : FLAG_FREE;
      rdOpen = 1'b1;
      dataIn <= {DATA_W{rdVal}};
    end else begin
      rdOpen = 1'b0;
      dataIn <= ~dataIn;         // released bus toggles, never stale
    end
  end

  // port B view of each flag, low when B holds it
  always_comb begin
    for (int i = 0; i < FLAG_COUNT; i++) bFlag[i] = (owner[i] != 2'd2);
  end
endmodule

// ---- dual_port_semaphore_flags_bench.sv ----
// self-checking bench: host controller against the behavioural flag device
// assumes port B of the device is worked directly by the bench
`timescale 1ns/1ps

module dual_port_semaphore_flags_bench;
  import dpsf_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                  clk, rst, cmdValid, cmdReady, rspValid, rspGranted, rspFlag;
  dpsf_op_t              cmdOp;
  logic [IDX_W-1:0]      cmdIndex, flagIndexLines, bIdx;
  logic [FLAG_COUNT-1:0] heldMask, bFlag;
  logic                  tokenSpaceSelectN, oeN, rwN, dataOe, bWr, bBit;
  logic [UPPER_W-1:0]    upperAddrLines;
  logic [DATA_W-1:0]     dataOut, dataIn;
  int                    pinErr, errCount, checksDone;

  dpsf_host dut_u (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdOp(cmdOp), .cmdIndex(cmdIndex), .rspValid(rspValid), .rspGranted(rspGranted),
    .rspFlag(rspFlag), .heldMask(heldMask), .tokenSpaceSelectN(tokenSpaceSelectN),
    .oeN(oeN), .rwN(rwN), .flagIndexLines(flagIndexLines),
    .upperAddrLines(upperAddrLines), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn));

  dpsf_dev_model dev_u (.clk(clk), .tokenSpaceSelectN(tokenSpaceSelectN), .oeN(oeN),
    .rwN(rwN), .flagIndexLines(flagIndexLines), .dataOut(dataOut), .dataOe(dataOe),
    .dataIn(dataIn), .bWr(bWr), .bIdx(bIdx), .bBit(bBit), .bFlag(bFlag), .pinErr(pinErr));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // verdict and end of run
  task automatic finishTest();
    if (errCount == 0 && checksDone > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait for the answer pulse
  task automatic waitResp();
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (rspValid !== 1'b1 && n < 400);
    if (rspValid !== 1'b1) begin
      errCount++;
      finishTest();
    end
  endtask

  // one command: hold valid until taken, then await the answer
  task automatic runCmd(input dpsf_op_t op, input int idx);
    int n;
    n = 0;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdIndex <= idx[IDX_W-1:0];
    do begin @(posedge clk); n++; end while (cmdReady !== 1'b1 && n < 100);
    cmdValid <= 1'b0;
    if (cmdReady !== 1'b1) begin
      errCount++;
      finishTest();
    end
    waitResp();
  endtask

  // port B flag write, settled one edge after it lands
  task automatic bWrite(input int idx, input logic v);
    @(posedge clk);
    bWr <= 1'b1;
    bIdx <= idx[IDX_W-1:0];
    bBit <= v;
    @(posedge clk);
    bWr <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic tInit();
    waitResp();
    check(heldMask, 8'h00);
    check(upperAddrLines, 12'h000);
    check(bFlag, 8'h00);
    for (int i = 0; i < FLAG_COUNT; i++) bWrite(i, 1'b1);
    check(bFlag, 8'hFF);
  endtask

  task automatic tHandOver();
    runCmd(OP_CLAIM, 3);
    check(rspGranted, 1'b1);
    check(rspFlag, 1'b0);
    check(heldMask, 8'h08);
    check(bFlag, 8'hFF);
    bWrite(3, 1'b0);
    check(bFlag, 8'hFF);
    runCmd(OP_PEEK, 3);
    check(rspGranted, 1'b1);
    runCmd(OP_RELEASE, 3);
    check(heldMask, 8'h00);
    check(bFlag, 8'hF7);
    runCmd(OP_PEEK, 3);
    check(rspFlag, 1'b1);
  endtask

  task automatic tFailedClaim();
    runCmd(OP_CLAIM, 3);
    check(rspGranted, 1'b0);
    check(heldMask, 8'h00);
    bWrite(3, 1'b1);
    check(bFlag, 8'hFF);
    runCmd(OP_PEEK, 3);
    check(rspFlag, 1'b1);
  endtask

  task automatic tPollWin();
    bWrite(6, 1'b0);
    fork
      runCmd(OP_CLAIM, 6);
      begin
        repeat (60) @(posedge clk);
        bWrite(6, 1'b1);
      end
    join
    check(rspGranted, 1'b1);
    check(heldMask, 8'h40);
    runCmd(OP_RELEASE, 6);
  endtask

  task automatic tAllFlags();
    for (int i = 0; i < FLAG_COUNT; i++) runCmd(OP_CLAIM, i);
    check(heldMask, 8'hFF);
    runCmd(OP_INIT, 0);
    check(heldMask, 8'h00);
    check(bFlag, 8'hFF);
    bWrite(5, 1'b0);
    check(bFlag, 8'hDF);
    bWrite(5, 1'b1);
    check(pinErr[15:0], 16'h0000);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {errCount, checksDone} = '0;
    {cmdValid, cmdIndex, bWr, bIdx, bBit} = '0;
    cmdOp = OP_PEEK;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    tInit();
    tHandOver();
    bWrite(3, 1'b1);
    bWrite(3, 1'b0);
    tFailedClaim();
    tPollWin();
    tAllFlags();
    finishTest();
  end
endmodule
